// [hw/exc_entry_consts.svh]
`ifndef EXC_ENTRY_CONSTS_SVH
`define EXC_ENTRY_CONSTS_SVH

// ==========================================================
// Vectors
`define PROGRAM_VEC_OFFSET  64'h0000_0000_0000_0700
`define FP_UNAVAIL_VEC_OFF  64'h0000_0000_0000_0800
`define VEC_BASE_HIGH       64'h0000_0000_fff0_0000
`define VEC_OFFSET_MASK     64'h0000_0000_000f_ffff

// ==========================================================
// Machine state bit positions (bit 63 is the most significant)
`define POS_SIXTY_FOUR      63
`define POS_INT_SIXTY_FOUR  61
`define POS_POWER_SAVE      18
`define POS_INT_LITTLE_END  16
`define POS_EXT_IRQ         15
`define POS_PROBLEM         14
`define POS_FLOAT_AVAIL     13
`define POS_MCHECK_ENABLE   12
`define POS_FEXC_LOW        11
`define POS_STEP_TRACE      10
`define POS_BRANCH_TRACE    9
`define POS_FEXC_HIGH       8
`define POS_PREFIX          6
`define POS_INSTR_XLATE     5
`define POS_DATA_XLATE      4
`define POS_RECOVERABLE     1
`define POS_LITTLE_END      0

// ==========================================================
// Saved state layout
`define SAVED_COPY_MASK     64'h8000_0000_0000_ff73
`define SAVED_CAUSE_LSB     16
`define SAVED_CAUSE_MSB     20

// ==========================================================
// Register offsets and reset values
`define OFF_MACHINE_STATE   8'h00
`define OFF_RETURN_ADDR     8'h08
`define OFF_SAVED_STATE     8'h10
`define OFF_IRQ_STATUS      8'h18
`define OFF_IRQ_MASK        8'h20
`define MACHINE_STATE_RESET 64'h8000_0000_0000_0000
`define IRQ_PROG_BIT        0
`define IRQ_FP_BIT          1

`endif

// [hw/exc_entry_pkg.sv]
package exc_entry_pkg;
    typedef logic [63:0] dword_t;
    typedef enum logic [1:0] {
        EXC_NONE,
        EXC_PROGRAM,
        EXC_FP_UNAVAIL
    } exc_kind_t;
endpackage

// [hw/exc_state_builder.sv]
`timescale 1ns/1ps
`include "exc_entry_consts.svh"

module exc_state_builder (
    input  wire exc_entry_pkg::exc_kind_t kind,        // Exception being entered
    input  wire exc_entry_pkg::dword_t    mctl,        // Current machine state
    input  wire logic [4:0]               prog_flags,  // Program cause flags
    output exc_entry_pkg::dword_t         next_mctl,   // Machine state after entry
    output exc_entry_pkg::dword_t         next_saved,  // Saved state value
    output exc_entry_pkg::dword_t         target       // Fetch address
);
    function automatic exc_entry_pkg::dword_t vector_addr(input logic prefix,
                                                          input exc_entry_pkg::dword_t off);
        vector_addr = (prefix ? `VEC_BASE_HIGH : 64'h0) | off;
    endfunction

    always_comb begin
        next_mctl = mctl;
        next_mctl[`POS_SIXTY_FOUR]   = 1'b1;
        next_mctl[`POS_POWER_SAVE]   = 1'b0;
        next_mctl[`POS_EXT_IRQ]      = 1'b0;
        next_mctl[`POS_PROBLEM]      = 1'b0;
        next_mctl[`POS_FLOAT_AVAIL]  = 1'b0;
        next_mctl[`POS_FEXC_LOW]     = 1'b0;
        next_mctl[`POS_STEP_TRACE]   = 1'b0;
        next_mctl[`POS_BRANCH_TRACE] = 1'b0;
        next_mctl[`POS_FEXC_HIGH]    = 1'b0;
        next_mctl[`POS_INSTR_XLATE]  = 1'b0;
        next_mctl[`POS_DATA_XLATE]   = 1'b0;
        next_mctl[`POS_RECOVERABLE]  = 1'b0;
        next_mctl[`POS_LITTLE_END]   = mctl[`POS_INT_LITTLE_END];
        // Copy fixed fields, clear the rest
        next_saved = mctl & `SAVED_COPY_MASK;
        if (kind == exc_entry_pkg::EXC_PROGRAM) begin
            next_saved[`SAVED_CAUSE_MSB:`SAVED_CAUSE_LSB] = prog_flags;
        end
        unique case (kind)
            exc_entry_pkg::EXC_PROGRAM:
                target = vector_addr(mctl[`POS_PREFIX], `PROGRAM_VEC_OFFSET);
            exc_entry_pkg::EXC_FP_UNAVAIL:
                target = vector_addr(mctl[`POS_PREFIX], `FP_UNAVAIL_VEC_OFF);
            default:
                target = 64'h0;
        endcase
    end
endmodule

// [hw/program_fp_unavail_exception_entry.sv]
`timescale 1ns/1ps
`include "exc_entry_consts.svh"

module program_fp_unavail_exception_entry (
    input  wire logic        clock,               // 50 MHz clock
    input  wire logic        rst,                 // Sync reset, active high
    input  wire logic        ce,                  // Clock enable
    input  wire logic        prog_req,            // Program exception request
    input  wire logic [4:0]  prog_flags,          // Program cause flags
    input  wire logic [63:0] prog_ea,             // Program excepting address
    input  wire logic        fp_attempt,          // Float instruction attempted
    input  wire logic [63:0] fp_instr_ea,         // Float instruction address
    input  wire logic        higher_prio_pending, // Higher exception pending
    input  wire logic [7:0]  reg_addr,            // Register byte address
    input  wire logic [63:0] reg_wdata,           // Write data
    input  wire logic        reg_wr,              // Write strobe
    input  wire logic        reg_rd,              // Read strobe
    output logic      [63:0] reg_rdata,           // Read data, cycle after read
    output logic             fetch_redirect,      // One-cycle redirect pulse
    output logic      [63:0] fetch_target,        // Redirect address
    output logic      [63:0] machine_state,       // Machine state value
    output logic             irq                  // Level interrupt
);
    exc_entry_pkg::dword_t    mctl_q, mctl_d;
    exc_entry_pkg::dword_t    ret_addr_q, ret_addr_d;
    exc_entry_pkg::dword_t    saved_q, saved_d;
    exc_entry_pkg::dword_t    rdata_q, rdata_d;
    exc_entry_pkg::dword_t    target_q, target_d;
    exc_entry_pkg::dword_t    entry_mctl, entry_saved, entry_target;
    logic               [1:0] status_q, status_d;
    logic               [1:0] mask_q, mask_d;
    logic                     redirect_q, redirect_d;
    logic                     irq_q, irq_d;
    logic                     prog_take, fp_take;
    exc_entry_pkg::exc_kind_t kind;

    // ==========================================================
    // Exception selection
    always_comb begin
        prog_take = prog_req && !higher_prio_pending;
        fp_take   = fp_attempt && !mctl_q[`POS_FLOAT_AVAIL] &&
                    !higher_prio_pending && !prog_req;
        if (prog_take) begin
            kind = exc_entry_pkg::EXC_PROGRAM;
        end else if (fp_take) begin
            kind = exc_entry_pkg::EXC_FP_UNAVAIL;
        end else begin
            kind = exc_entry_pkg::EXC_NONE;
        end
    end

    exc_state_builder builder (
        .kind       (kind),
        .mctl       (mctl_q),
        .prog_flags (prog_flags),
        .next_mctl  (entry_mctl),
        .next_saved (entry_saved),
        .target     (entry_target)
    );

    // ==========================================================
    // Next state
    always_comb begin
        mctl_d     = mctl_q;
        ret_addr_d = ret_addr_q;
        saved_d    = saved_q;
        status_d   = status_q;
        mask_d     = mask_q;
        target_d   = target_q;
        redirect_d = 1'b0;
        rdata_d    = 64'h0;
        if (reg_wr) begin
            unique case (reg_addr)
                `OFF_MACHINE_STATE: mctl_d     = reg_wdata;
                `OFF_RETURN_ADDR:   ret_addr_d = reg_wdata;
                `OFF_SAVED_STATE:   saved_d    = reg_wdata;
                `OFF_IRQ_MASK:      mask_d     = reg_wdata[1:0];
                default:            ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `OFF_MACHINE_STATE: rdata_d = mctl_q;
                `OFF_RETURN_ADDR:   rdata_d = ret_addr_q;
                `OFF_SAVED_STATE:   rdata_d = saved_q;
                `OFF_IRQ_STATUS: begin
                    rdata_d  = {62'h0, status_q};
                    status_d = 2'h0;
                end
                `OFF_IRQ_MASK:      rdata_d = {62'h0, mask_q};
                default:            rdata_d = 64'h0;
            endcase
        end
        // Entry overrides a same-cycle software write
        if (kind != exc_entry_pkg::EXC_NONE) begin
            mctl_d     = entry_mctl;
            saved_d    = entry_saved;
            target_d   = entry_target;
            redirect_d = 1'b1;
        end
        if (prog_take) begin
            ret_addr_d              = prog_ea;
            status_d[`IRQ_PROG_BIT] = 1'b1;
        end
        if (fp_take) begin
            ret_addr_d            = fp_instr_ea;
            status_d[`IRQ_FP_BIT] = 1'b1;
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mctl_q     <= `MACHINE_STATE_RESET;
            ret_addr_q <= 64'h0;
            saved_q    <= 64'h0;
            status_q   <= 2'h0;
            mask_q     <= 2'h0;
            target_q   <= 64'h0;
            redirect_q <= 1'b0;
            rdata_q    <= 64'h0;
            irq_q      <= 1'b0;
        end else if (ce) begin
            mctl_q     <= mctl_d;
            ret_addr_q <= ret_addr_d;
            saved_q    <= saved_d;
            status_q   <= status_d;
            mask_q     <= mask_d;
            target_q   <= target_d;
            redirect_q <= redirect_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    assign reg_rdata      = rdata_q;
    assign fetch_redirect = redirect_q;
    assign fetch_target   = target_q;
    assign machine_state  = mctl_q;
    assign irq            = irq_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence prog_entry_s;
        ce && prog_take;
    endsequence

    sequence fp_entry_s;
        ce && fp_take;
    endsequence

    sequence any_entry_s;
        ce && (prog_take || fp_take);
    endsequence

    prog_vector_a: assert property (prog_entry_s |=> fetch_redirect &&
        (fetch_target & `VEC_OFFSET_MASK) == `PROGRAM_VEC_OFFSET &&
        (fetch_target[31:20] == ($past(mctl_q[`POS_PREFIX]) ? 12'hfff : 12'h000)))
        else $error("program vector wrong");

    fp_detect_a: assert property (ce && fp_attempt && !mctl_q[`POS_FLOAT_AVAIL] &&
        !higher_prio_pending && !prog_req |=> fetch_redirect && status_q[`IRQ_FP_BIT])
        else $error("float unavailable not taken");

    fp_priority_a: assert property (ce && fp_attempt &&
        (higher_prio_pending || mctl_q[`POS_FLOAT_AVAIL]) && !prog_req |=> !fetch_redirect)
        else $error("float trap taken under priority");

    fp_addr_a: assert property (fp_entry_s |=> ret_addr_q == $past(fp_instr_ea))
        else $error("saved address wrong");

    fp_saved_a: assert property (fp_entry_s |=>
        (saved_q & `SAVED_COPY_MASK) == ($past(mctl_q) & `SAVED_COPY_MASK) &&
        (saved_q & ~`SAVED_COPY_MASK) == 64'h0)
        else $error("saved state wrong");

    fp_vector_a: assert property (fp_entry_s |=> fetch_redirect &&
        (fetch_target & `VEC_OFFSET_MASK) == `FP_UNAVAIL_VEC_OFF)
        else $error("float vector wrong");

    mode_entry_a: assert property (any_entry_s |=> mctl_q[`POS_SIXTY_FOUR] &&
        !mctl_q[`POS_EXT_IRQ] && !mctl_q[`POS_PROBLEM] && !mctl_q[`POS_FLOAT_AVAIL] &&
        !mctl_q[`POS_INSTR_XLATE] && !mctl_q[`POS_POWER_SAVE] &&
        mctl_q[`POS_LITTLE_END] == $past(mctl_q[`POS_INT_LITTLE_END]) &&
        mctl_q[`POS_MCHECK_ENABLE] == $past(mctl_q[`POS_MCHECK_ENABLE]) &&
        mctl_q[`POS_PREFIX] == $past(mctl_q[`POS_PREFIX]))
        else $error("machine state after entry wrong");

    // ==========================================================
    // Program entry and priority
    sequence status_read_s;
        ce && reg_rd && reg_addr == `OFF_IRQ_STATUS;
    endsequence

    prog_save_a: assert property (prog_entry_s |=> ret_addr_q == $past(prog_ea) &&
        saved_q[`SAVED_CAUSE_MSB:`SAVED_CAUSE_LSB] == $past(prog_flags))
        else $error("program save wrong");

    prog_first_a: assert property (ce && prog_take && fp_attempt |=>
        status_q[`IRQ_PROG_BIT] && ret_addr_q == $past(prog_ea))
        else $error("float trap beat program");

    status_wins_a: assert property (fp_entry_s ##0 status_read_s |=> status_q[`IRQ_FP_BIT])
        else $error("status set lost to read");

    // ==========================================================
    // Register port and clock enable
    irq_level_a: assert property (irq == |(status_q & mask_q))
        else $error("interrupt level wrong");

    read_data_a: assert property (ce && reg_rd && reg_addr == `OFF_MACHINE_STATE |=>
        reg_rdata == $past(mctl_q))
        else $error("read data wrong");

    read_idle_a: assert property (ce && !reg_rd |=>
        reg_rdata == 64'h0)
        else $error("read data not cleared");

    freeze_a: assert property (!ce |=> $stable(mctl_q) && $stable(status_q) &&
        $stable(fetch_redirect) && $stable(reg_rdata))
        else $error("state moved while frozen");
endmodule

// [tb/exc_seq_model.sv]
`timescale 1ns/1ps
module exc_seq_model (
    input  wire logic        clock,                // Core clock
    input  wire logic        go,                   // Present one request
    input  wire logic [1:0]  kind,                 // 1 program, 2 float
    input  wire logic [63:0] ea,                   // Instruction address
    input  wire logic [4:0]  flags,                // Program causes
    output logic             prog_req = 1'b0,      // Program request
    output logic             fp_attempt = 1'b0,    // Float attempt
    output logic [63:0]      prog_ea = 64'h0,      // Program address
    output logic [63:0]      fp_instr_ea = 64'h0,  // Float address
    output logic [4:0]       prog_flags = 5'h0     // Cause bits
);
    // ====================
    // One-cycle request, scrambled fields when idle
    always @(posedge clock) begin
        prog_req <= go && kind == 2'h1;
        fp_attempt <= go && kind == 2'h2;
        prog_ea <= go ? ea : ~prog_ea;
        fp_instr_ea <= go ? ea : ~fp_instr_ea;
        prog_flags <= go ? flags : ~prog_flags;
    end
endmodule

// [tb/tb_program_fp_unavail_exception_entry.sv]
`timescale 1ns/1ps
module tb_program_fp_unavail_exception_entry;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h0;
    logic [63:0] wdata = 64'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic        hp = 1'b0;
    logic        en = 1'b1;
    logic [1:0]  kind = 2'h1;
    logic [63:0] ea = 64'h0;
    logic [4:0]  flags = 5'h0;
    logic [63:0] rdata, target, mstate, p_ea, f_ea, rv, m;
    logic [4:0]  p_flags;
    logic        p_req, f_att, redirect, irq, taken, hp_n;
    logic [1:0]  mask;
    integer      seed = 11;
    integer      errors = 0;
    integer      comparisons = 0;

    always #10 clock = ~clock;

    exc_seq_model seq (.clock(clock), .go(go), .kind(kind), .ea(ea), .flags(flags),
        .prog_req(p_req), .fp_attempt(f_att), .prog_ea(p_ea), .fp_instr_ea(f_ea),
        .prog_flags(p_flags));

    program_fp_unavail_exception_entry DUT (.clock(clock), .rst(rst), .ce(en),
        .prog_req(p_req), .prog_flags(p_flags), .prog_ea(p_ea), .fp_attempt(f_att),
        .fp_instr_ea(f_ea), .higher_prio_pending(hp), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .fetch_redirect(redirect), .fetch_target(target), .machine_state(mstate),
        .irq(irq));

    // ====================
    // Helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [63:0] d);
        @(posedge clock);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    function automatic logic [63:0] exp_mctl(input logic [63:0] v);
        return (v & ~64'h0000_0000_0004_ef33) | 64'h8000_0000_0000_0000 | {63'h0, v[16]};
    endfunction

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ====================
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        #1 chk(mstate, 64'h8000_0000_0000_0000);
        bus(1'b0, 8'h28, 64'h0);
        chk(rv, 64'h0);
        for (int i = 0; i < 24; i++) begin
            m = {$random(seed), $random(seed)};
            kind = 2'h1 + 2'($random(seed) & 1);
            hp_n = ($random(seed) & 3) == 0;
            if (i < 4) begin
                m[13] = 1'b0;
                m[6] = i[0];
                kind = 2'h2;
                hp_n = 1'b0;
            end
            mask = 2'($random(seed));
            ea = {$random(seed), $random(seed)};
            flags = 5'($random(seed));
            taken = !hp_n && (kind == 2'h1 || !m[13]);
            bus(1'b1, 8'h00, m);
            bus(1'b1, 8'h20, {62'h0, mask});
            @(posedge clock);
            go <= 1'b1;
            hp <= hp_n;
            @(posedge clock);
            go <= 1'b0;
            @(posedge clock);
            #1 chk({63'h0, redirect}, {63'h0, taken});
            if (taken) begin
                chk(target, (m[6] ? 64'hfff0_0000 : 64'h0) | (kind == 2'h1 ? 64'h700 : 64'h800));
                chk(mstate, exp_mctl(m));
                bus(1'b0, 8'h08, 64'h0);
                chk(rv, ea);
                bus(1'b0, 8'h10, 64'h0);
                chk(rv, (m & 64'h8000_0000_0000_ff73) | (kind == 2'h1 ? {43'h0, flags, 16'h0} : 64'h0));
            end else begin
                chk(mstate, m);
            end
            chk({63'h0, irq}, {63'h0, taken & mask[kind - 2'h1]});
            bus(1'b0, 8'h18, 64'h0);
            chk(rv, taken ? {62'h0, kind} : 64'h0);
            @(posedge clock);
            #1 chk({62'h0, redirect, irq}, 64'h0);
        end
        // Clock enable low: write and request both ignored
        m = mstate;
        kind = 2'h1;
        @(posedge clock);
        en <= 1'b0;
        bus(1'b1, 8'h00, ~m);
        @(posedge clock);
        go <= 1'b1;
        hp <= 1'b0;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        en <= 1'b1;
        #1 chk({63'h0, redirect}, 64'h0);
        chk(mstate, m);
        tally_and_finish;
    end

    initial begin
        repeat (4000) @(posedge clock);
        errors++;
        tally_and_finish;
    end
endmodule
